// >>> include/timing_pin_defs.vh
/*
 * Register offsets, field positions, reset values and source-select codes
 * for the timing pin selector.
 * Assumes an 8-bit register address and 16-bit register data.
 */
`ifndef TIMING_PIN_DEFS_VH
`define TIMING_PIN_DEFS_VH

// Register offsets
`define ADDR_INT_STATUS 8'h00
`define ADDR_INT_MASK 8'h01
`define ADDR_PIN_DRIVE 8'h02
`define ADDR_QUEUE_LIMIT 8'h06
`define ADDR_PIN_SELECT 8'h0B
`define ADDR_PIN1_ENABLE 8'h4F

// Interrupt status and mask bit positions
`define BIT_INT_SLOT_A 5
`define BIT_INT_SLOT_B 6
`define BIT_INT_QUEUE 8

// Pin drive configuration bit positions
`define BIT_PIN0_POLARITY 0
`define BIT_PIN0_OPEN_DRAIN 1
`define BIT_PIN0_ENABLE 2
`define BIT_PIN1_POLARITY 8
`define BIT_PIN1_OPEN_DRAIN 9
`define BIT_PIN1_ENABLE 6

// Source select fields and queue level limit field
`define SEL_PIN0_LSB 0
`define SEL_PIN1_LSB 8
`define SEL_WIDTH 5
`define QUEUE_LIMIT_LSB 8
`define QUEUE_LIMIT_WIDTH 6

// Reset values
`define RST_INT_MASK 16'h0160
`define RST_PIN_DRIVE 16'h0000
`define RST_PIN_SELECT 16'h0000
`define RST_PIN1_ENABLE 1'b0
`define RST_QUEUE_LIMIT 6'h00

// Source select codes
`define SRC_INTERRUPT 5'h01
`define SRC_ENVELOPE 5'h02
`define SRC_LED_A 5'h05
`define SRC_LED_B 5'h06
`define SRC_LED_AB 5'h07
`define SRC_WRITTEN_A 5'h0C
`define SRC_WRITTEN_B 5'h0D
`define SRC_WRITTEN_AB 5'h0E
`define SRC_HALF_RATE 5'h0F
`define SRC_LOGIC_0 5'h10
`define SRC_LOGIC_1 5'h11
`define SRC_OSC_32K 5'h13

`endif

// >>> verilog/timing_pin_driver.v
/*
 * One timing pin: source selection, polarity and drive gating, registered.
 * Assumes all inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "timing_pin_defs.vh"

module timing_pin_driver (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Configuration
    input wire [4:0] sel,
    input wire polarity,
    input wire open_drain,
    input wire drive_en,
    // Internal timing signals
    input wire irq,
    input wire envelope,
    input wire led_a,
    input wire led_b,
    input wire written_a,
    input wire written_b,
    input wire half_rate,
    input wire osc_32k,
    // Pin
    output reg pin_out,
    output reg pin_oe
);

    reg selected;

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    always @* begin
        case (sel)
            `SRC_INTERRUPT: selected = irq;
            `SRC_ENVELOPE: selected = envelope;
            `SRC_LED_A: selected = led_a;
            `SRC_LED_B: selected = led_b;
            `SRC_LED_AB: selected = led_a | led_b;
            `SRC_WRITTEN_A: selected = written_a;
            `SRC_WRITTEN_B: selected = written_b;
            `SRC_WRITTEN_AB: selected = written_a | written_b;
            `SRC_HALF_RATE: selected = half_rate;
            `SRC_LOGIC_0: selected = 1'b0;
            `SRC_LOGIC_1: selected = 1'b1;
            `SRC_OSC_32K: selected = osc_32k;
            default: selected = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Polarity inverts the level only; drive enable, then open-drain release on the raw source
    always @(posedge clk) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_out <= selected ^ polarity;
            if (!drive_en) begin
                pin_oe <= 1'b0;
            end else if (open_drain) begin
                pin_oe <= selected;
            end else begin
                pin_oe <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// >>> verilog/timing_signal_pin_selector.v
/*
 * Timing signal pin selector: registers, timing signal generation and the
 * two timing pin drivers.
 * Assumes the sequencer, LED drivers, data path and sample queue of the
 * device supply synchronous pulses and levels on CLK, and that the serial
 * port supplies single-cycle register read and write strobes.
 */
// Functional notes
// - Polarity bit per pin, bit 0 and bit 8: set inverts to active low.
// - Drive-mode bit per pin, bit 1 and bit 9: set drives only while asserted.
// - First pin driven only while its enable bit 2 is set.
// - Second pin driven only while its enable bit in register second_pin_drive_enable is set.
// - One register holds 5-bit selects: bits 12:8 second pin, 4:0 first pin.
// - Every timing signal can go to either pin, or both at once.
// - Code 0x01 puts the masked interrupt output on the pin.
// - Code 0x02 spans first enabled slot start to last enabled slot end.
// - With one slot enabled the envelope covers just that slot.
// - Codes 0x05, 0x06, 0x07 copy slot A, slot B, both LED pulses.
// - Codes 0x0C, 0x0D, 0x0E mark data written for A, B, either.
// - Written strobe rises at slot end after write, falls at next sample start.
// - Code 0x0F is a square wave toggling once per sample.
// - Half-rate wave starts low on entering normal mode, rises after first sample.
// - Codes 0x10 and 0x11 give constant logic 0 and logic 1.
// - Code 0x13 copies the 32 kHz oscillator.
// - Mask bit written 0 enables: bit 5 slot A, 6 slot B, 8 queue.
// - Queue interrupt clears on a queue read, sets on write above limit; the set wins if both come in one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "timing_pin_defs.vh"

module timing_signal_pin_selector #(
    parameter COUNT_WIDTH = 8
) (
    // Clock and reset
    input wire CLK,
    input wire RST_N,
    // Register access from the serial port
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [15:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    // Sequencer state
    input wire SLOT_A_ENABLED,
    input wire SLOT_B_ENABLED,
    input wire ENTER_NORMAL,
    input wire SAMPLE_START,
    input wire SAMPLE_DONE,
    input wire SLOT_A_START,
    input wire SLOT_A_END,
    input wire SLOT_B_START,
    input wire SLOT_B_END,
    // LED pulses and oscillator
    input wire LED_A_PULSE,
    input wire LED_B_PULSE,
    input wire OSC_32K,
    // Data path and queue events
    input wire DATA_WRITTEN_A,
    input wire DATA_WRITTEN_B,
    input wire QUEUE_WRITE,
    input wire QUEUE_READ,
    input wire [COUNT_WIDTH-1:0] QUEUE_COUNT,
    // Timing pins
    output wire TIMING_PIN_ZERO_OUT,
    output wire TIMING_PIN_ZERO_OE,
    output wire TIMING_PIN_ONE_OUT,
    output wire TIMING_PIN_ONE_OE,
    // Interrupt level as seen by the pins
    output reg IRQ
);

    // Configuration registers
    reg [15:0] int_mask_reg;
    reg [15:0] pin_drive_config_reg;
    reg [15:0] pin_signal_select_reg;
    reg second_pin_drive_enable_reg;
    reg [`QUEUE_LIMIT_WIDTH-1:0] queue_level_limit_reg;

    // Interrupt flags
    reg flag_slot_a_reg;
    reg flag_slot_b_reg;
    reg flag_queue_reg;
    reg flag_slot_a_next;
    reg flag_slot_b_next;
    reg flag_queue_next;

    // Timing signals
    reg envelope_reg;
    reg envelope_next;
    reg written_a_reg;
    reg written_b_reg;
    reg half_rate_reg;
    reg led_a_reg;
    reg led_b_reg;
    reg osc_reg;

    wire wr_status;
    wire queue_above_limit;
    wire env_set;
    wire env_clear;
    reg [15:0] rdata_next;

    wire [9:0] pin_sel;
    wire [1:0] pin_pol;
    wire [1:0] pin_od;
    wire [1:0] pin_en;
    wire [1:0] pin_out;
    wire [1:0] pin_oe;

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge CLK) begin
        if (!RST_N) begin
            int_mask_reg <= `RST_INT_MASK;
            pin_drive_config_reg <= `RST_PIN_DRIVE;
            pin_signal_select_reg <= `RST_PIN_SELECT;
            second_pin_drive_enable_reg <= `RST_PIN1_ENABLE;
            queue_level_limit_reg <= `RST_QUEUE_LIMIT;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `ADDR_INT_MASK: begin
                    int_mask_reg <= REG_WDATA;
                end
                `ADDR_PIN_DRIVE: begin
                    pin_drive_config_reg <= REG_WDATA;
                end
                `ADDR_PIN_SELECT: begin
                    pin_signal_select_reg <= REG_WDATA;
                end
                `ADDR_PIN1_ENABLE: begin
                    second_pin_drive_enable_reg <= REG_WDATA[`BIT_PIN1_ENABLE];
                end
                `ADDR_QUEUE_LIMIT: begin
                    queue_level_limit_reg <=
                        REG_WDATA[`QUEUE_LIMIT_LSB +: `QUEUE_LIMIT_WIDTH];
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags: a setting event wins over a clear in the same cycle
    assign wr_status = REG_WR && (REG_ADDR == `ADDR_INT_STATUS);
    assign queue_above_limit =
        (QUEUE_COUNT > {{(COUNT_WIDTH-`QUEUE_LIMIT_WIDTH){1'b0}}, queue_level_limit_reg});

    always @* begin
        flag_slot_a_next = flag_slot_a_reg;
        flag_slot_b_next = flag_slot_b_reg;
        flag_queue_next = flag_queue_reg;
        if (wr_status && REG_WDATA[`BIT_INT_SLOT_A]) begin
            flag_slot_a_next = 1'b0;
        end
        if (wr_status && REG_WDATA[`BIT_INT_SLOT_B]) begin
            flag_slot_b_next = 1'b0;
        end
        if (DATA_WRITTEN_A) begin
            flag_slot_a_next = 1'b1;
        end
        if (DATA_WRITTEN_B) begin
            flag_slot_b_next = 1'b1;
        end
        if (QUEUE_READ) begin
            flag_queue_next = 1'b0;
        end
        if (QUEUE_WRITE && queue_above_limit) begin
            flag_queue_next = 1'b1;
        end
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            flag_slot_a_reg <= 1'b0;
            flag_slot_b_reg <= 1'b0;
            flag_queue_reg <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            flag_slot_a_reg <= flag_slot_a_next;
            flag_slot_b_reg <= flag_slot_b_next;
            flag_queue_reg <= flag_queue_next;
            IRQ <= (flag_slot_a_next & ~int_mask_reg[`BIT_INT_SLOT_A]) |
                   (flag_slot_b_next & ~int_mask_reg[`BIT_INT_SLOT_B]) |
                   (flag_queue_next & ~int_mask_reg[`BIT_INT_QUEUE]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample envelope: first enabled slot start to last enabled slot end
    assign env_set = (SLOT_A_START && SLOT_A_ENABLED) ||
                     (SLOT_B_START && SLOT_B_ENABLED && !SLOT_A_ENABLED);
    assign env_clear = (SLOT_B_END && SLOT_B_ENABLED) ||
                       (SLOT_A_END && SLOT_A_ENABLED && !SLOT_B_ENABLED);

    always @* begin
        envelope_next = envelope_reg;
        if (env_clear) begin
            envelope_next = 1'b0;
        end
        if (env_set) begin
            envelope_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timing signal generation
    always @(posedge CLK) begin
        if (!RST_N) begin
            envelope_reg <= 1'b0;
            written_a_reg <= 1'b0;
            written_b_reg <= 1'b0;
            half_rate_reg <= 1'b0;
            led_a_reg <= 1'b0;
            led_b_reg <= 1'b0;
            osc_reg <= 1'b0;
        end else begin
            envelope_reg <= envelope_next;
            led_a_reg <= LED_A_PULSE;
            led_b_reg <= LED_B_PULSE;
            osc_reg <= OSC_32K;
            // Written strobes hold from slot end until the next sample starts
            if (DATA_WRITTEN_A) begin
                written_a_reg <= 1'b1;
            end else if (SAMPLE_START) begin
                written_a_reg <= 1'b0;
            end
            if (DATA_WRITTEN_B) begin
                written_b_reg <= 1'b1;
            end else if (SAMPLE_START) begin
                written_b_reg <= 1'b0;
            end
            if (ENTER_NORMAL) begin
                half_rate_reg <= 1'b0;
            end else if (SAMPLE_DONE) begin
                half_rate_reg <= ~half_rate_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    always @* begin
        rdata_next = 16'h0000;
        case (REG_ADDR)
            `ADDR_INT_STATUS: begin
                rdata_next[`BIT_INT_SLOT_A] = flag_slot_a_reg;
                rdata_next[`BIT_INT_SLOT_B] = flag_slot_b_reg;
                rdata_next[`BIT_INT_QUEUE] = flag_queue_reg;
            end
            `ADDR_INT_MASK: begin
                rdata_next = int_mask_reg;
            end
            `ADDR_PIN_DRIVE: begin
                rdata_next = pin_drive_config_reg;
            end
            `ADDR_PIN_SELECT: begin
                rdata_next = pin_signal_select_reg;
            end
            `ADDR_PIN1_ENABLE: begin
                rdata_next[`BIT_PIN1_ENABLE] = second_pin_drive_enable_reg;
            end
            `ADDR_QUEUE_LIMIT: begin
                rdata_next[`QUEUE_LIMIT_LSB +: `QUEUE_LIMIT_WIDTH] =
                    queue_level_limit_reg;
            end
            default: begin
                rdata_next = 16'h0000;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin configuration and drivers
    assign pin_sel[4:0] = pin_signal_select_reg[`SEL_PIN0_LSB +: `SEL_WIDTH];
    assign pin_sel[9:5] = pin_signal_select_reg[`SEL_PIN1_LSB +: `SEL_WIDTH];
    assign pin_pol = {pin_drive_config_reg[`BIT_PIN1_POLARITY],
                      pin_drive_config_reg[`BIT_PIN0_POLARITY]};
    assign pin_od = {pin_drive_config_reg[`BIT_PIN1_OPEN_DRAIN],
                     pin_drive_config_reg[`BIT_PIN0_OPEN_DRAIN]};
    assign pin_en = {second_pin_drive_enable_reg,
                     pin_drive_config_reg[`BIT_PIN0_ENABLE]};

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_pin
            timing_pin_driver u_drv (
                .clk(CLK),
                .rst_n(RST_N),
                .sel(pin_sel[i*5 +: 5]),
                .polarity(pin_pol[i]),
                .open_drain(pin_od[i]),
                .drive_en(pin_en[i]),
                .irq(IRQ),
                .envelope(envelope_reg),
                .led_a(led_a_reg),
                .led_b(led_b_reg),
                .written_a(written_a_reg),
                .written_b(written_b_reg),
                .half_rate(half_rate_reg),
                .osc_32k(osc_reg),
                .pin_out(pin_out[i]),
                .pin_oe(pin_oe[i])
            );
        end
    endgenerate

    assign TIMING_PIN_ZERO_OUT = pin_out[0];
    assign TIMING_PIN_ZERO_OE = pin_oe[0];
    assign TIMING_PIN_ONE_OUT = pin_out[1];
    assign TIMING_PIN_ONE_OE = pin_oe[1];

endmodule
`default_nettype wire

// >>> verif/timing_pin_checker_asserts.sv
/* Checker for the timing pin selector: pin level and enable against shadowed settings.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module timing_pin_checker (
    // Clock, reset and register writes
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    // Events
    input wire logic LED_A_PULSE,
    input wire logic DATA_WRITTEN_A,
    input wire logic SAMPLE_START,
    // Pins
    input wire logic TIMING_PIN_ZERO_OUT,
    input wire logic TIMING_PIN_ZERO_OE,
    input wire logic TIMING_PIN_ONE_OUT,
    input wire logic TIMING_PIN_ONE_OE,
    input wire logic IRQ
);
    logic [15:0] cfg_reg, sel_reg, cfg_p, sel_p;
    logic en1_reg, en1_p;
    wire push0 = cfg_p[2] && !cfg_p[1] && !cfg_p[0];
    ////////////////////////////////////////////////////////////////////////////
    // Shadow settings, delayed one cycle to line up with the pin flops
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cfg_reg <= 16'h0000;
            sel_reg <= 16'h0000;
            en1_reg <= 1'b0;
        end else if (REG_WR) begin
            if (REG_ADDR == 8'h02) cfg_reg <= REG_WDATA;
            if (REG_ADDR == 8'h0B) sel_reg <= REG_WDATA;
            if (REG_ADDR == 8'h4F) en1_reg <= REG_WDATA[6];
        end
        cfg_p <= cfg_reg;
        sel_p <= sel_reg;
        en1_p <= en1_reg;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_RESET_RELEASE: assert property ($rose(RST_N) |-> !TIMING_PIN_ZERO_OE
        && !TIMING_PIN_ONE_OE && !IRQ) else $error("pins driven after reset");
    AST_PIN0_OFF: assert property (!cfg_p[2] |-> !TIMING_PIN_ZERO_OE)
        else $error("pin zero driven while disabled");
    AST_PIN1_OFF: assert property (!en1_p |-> !TIMING_PIN_ONE_OE)
        else $error("pin one driven while disabled");
    AST_PUSH_PULL: assert property (cfg_p[2] && !cfg_p[1] |-> TIMING_PIN_ZERO_OE)
        else $error("push-pull pin zero released");
    AST_OPEN_DRAIN: assert property (cfg_p[2] && cfg_p[1] |->
        TIMING_PIN_ZERO_OE == (TIMING_PIN_ZERO_OUT ^ cfg_p[0])) else $error("open drain wrong");
    AST_PIN1_POLARITY: assert property (en1_p && !cfg_p[9] && sel_p[12:8] == 5'h11 |->
        TIMING_PIN_ONE_OE && TIMING_PIN_ONE_OUT == !cfg_p[8]) else $error("pin one polarity");
    AST_LED_COPY: assert property (push0 && sel_p[4:0] == 5'h05 |->
        TIMING_PIN_ZERO_OUT == $past(LED_A_PULSE, 2)) else $error("LED copy wrong");
    AST_WRITTEN_RISE: assert property (push0 && sel_p[4:0] == 5'h0C
        && $past(DATA_WRITTEN_A, 2) |-> TIMING_PIN_ZERO_OUT) else $error("strobe missing");
    AST_WRITTEN_FALL: assert property (push0 && sel_p[4:0] == 5'h0C
        && $past(SAMPLE_START, 2) && !$past(DATA_WRITTEN_A, 2) |-> !TIMING_PIN_ZERO_OUT)
        else $error("strobe stuck");
    AST_IRQ_PIN: assert property (push0 && sel_p[4:0] == 5'h01 |->
        TIMING_PIN_ZERO_OUT == $past(IRQ)) else $error("interrupt pin wrong");
endmodule
bind timing_signal_pin_selector timing_pin_checker timing_pin_checker_i (.CLK(CLK),
    .RST_N(RST_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .LED_A_PULSE(LED_A_PULSE), .DATA_WRITTEN_A(DATA_WRITTEN_A), .SAMPLE_START(SAMPLE_START),
    .TIMING_PIN_ZERO_OUT(TIMING_PIN_ZERO_OUT), .TIMING_PIN_ZERO_OE(TIMING_PIN_ZERO_OE),
    .TIMING_PIN_ONE_OUT(TIMING_PIN_ONE_OUT), .TIMING_PIN_ONE_OE(TIMING_PIN_ONE_OE), .IRQ(IRQ));
`default_nettype wire

// >>> verif/pin_line_model.sv
/* Far-side view of the two timing pins: the lines as a host sees them.
   Assumes each line carries a pull-up, so a released line reads high. */
`timescale 1ns/1ps
`default_nettype none
module pin_line_model (
    // Pin drivers
    input wire logic out0,
    input wire logic oe0,
    input wire logic out1,
    input wire logic oe1,
    // Resolved lines
    output logic line0,
    output logic line1
);
    assign line0 = oe0 ? out0 : 1'b1;
    assign line1 = oe1 ? out1 : 1'b1;
endmodule
`default_nettype wire

// >>> verif/timing_signal_pin_selector_test.sv
/* Self-checking bench for the timing pin selector.
   Assumes the design reads its settings over the register strobes. */
`timescale 1ns/1ps
`default_nettype none
module timing_signal_pin_selector_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0] slot_en = 2'b00;
    logic [1:0] led = 2'b00;
    logic osc = 1'b0;
    logic [10:0] evt = 11'h000;
    logic [7:0] count = 8'h00;
    wire [15:0] rdata;
    wire z_out, z_oe, o_out, o_oe, irq, line0, line1;
    int n_errors = 0;
    int tests_run = 0;
    always #12.5 clk = ~clk;
    timing_signal_pin_selector timing_signal_pin_selector_i (.CLK(clk), .RST_N(rst_n),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(rdata), .SLOT_A_ENABLED(slot_en[0]), .SLOT_B_ENABLED(slot_en[1]),
        .ENTER_NORMAL(evt[0]), .SAMPLE_START(evt[1]), .SAMPLE_DONE(evt[2]),
        .SLOT_A_START(evt[3]), .SLOT_A_END(evt[4]), .SLOT_B_START(evt[5]),
        .SLOT_B_END(evt[6]), .LED_A_PULSE(led[0]), .LED_B_PULSE(led[1]), .OSC_32K(osc),
        .DATA_WRITTEN_A(evt[7]), .DATA_WRITTEN_B(evt[8]), .QUEUE_WRITE(evt[9]),
        .QUEUE_READ(evt[10]), .QUEUE_COUNT(count), .TIMING_PIN_ZERO_OUT(z_out),
        .TIMING_PIN_ZERO_OE(z_oe), .TIMING_PIN_ONE_OUT(o_out), .TIMING_PIN_ONE_OE(o_oe),
        .IRQ(irq));
    pin_line_model pin_line_model_i (.out0(z_out), .oe0(z_oe), .out1(o_out), .oe1(o_oe),
        .line0(line0), .line1(line1));
    ////////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Each access leaves one more edge so the pins already show its effect
    task wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk("read data", exp, rdata);
        tick(1);
    endtask
    task pulse(input logic [10:0] m);
        evt = m;
        tick(1);
        evt = 11'h000;
        tick(1);
    endtask
    task cfg(input logic [4:0] s0, input logic [4:0] s1, input logic [15:0] drive);
        wr(8'h0B, {3'b000, s1, 3'b000, s0});
        wr(8'h02, drive);
        wr(8'h4F, 16'h0040);
    endtask
    task report_and_stop;
        $display("Errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_registers;
        rd(8'h01, 16'h0160);
        rd(8'h0B, 16'h0000);
        rd(8'h4F, 16'h0000);
        chk("pins released", 2'b00, {z_oe, o_oe});
        wr(8'h33, 16'hFFFF);
        rd(8'h33, 16'h0000);
        wr(8'h0B, 16'h1F1F);
        rd(8'h0B, 16'h1F1F);
        wr(8'h02, 16'h0307);
        rd(8'h02, 16'h0307);
    endtask
    task t_modes;
        logic [4:0] code;
        logic [1:0] m;
        logic src;
        for (int i = 0; i < 12; i++) begin
            m = 2'(i / 3);
            code = (i % 3 == 0) ? 5'h10 : (i % 3 == 1) ? 5'h11 : 5'h03;
            src = (i % 3 == 1);
            cfg(code, code, {6'h00, m[1], m[0], 5'h00, 1'b1, m[1], m[0]});
            chk("pin0 level", src ^ m[0], z_out);
            chk("pin0 enable", m[1] ? src : 1'b1, z_oe);
            chk("pin0 line", (m[1] && !src) ? 1'b1 : src ^ m[0], line0);
            chk("pin1 level", src ^ m[0], o_out);
            chk("pin1 line", (m[1] && !src) ? 1'b1 : src ^ m[0], line1);
        end
        wr(8'h02, 16'h0004);
        wr(8'h4F, 16'h0000);
        chk("enables", 2'b10, {z_oe, o_oe});
        wr(8'h02, 16'h0000);
        chk("pin0 enable", 1'b0, z_oe);
    endtask
    task t_events;
        cfg(5'h0E, 5'h0F, 16'h0004);
        pulse(11'h001);
        chk("half rate", 1'b0, o_out);
        pulse(11'h100);
        chk("written either", 1'b1, z_out);
        pulse(11'h004);
        chk("half rate", 1'b1, o_out);
        pulse(11'h002);
        chk("written either", 1'b0, z_out);
        pulse(11'h004);
        chk("half rate", 1'b0, o_out);
        pulse(11'h004);
        pulse(11'h001);
        chk("half rate", 1'b0, o_out);
        cfg(5'h0C, 5'h0D, 16'h0004);
        pulse(11'h080);
        chk("written A B", 2'b10, {z_out, o_out});
        pulse(11'h102);
        chk("written A B", 2'b01, {z_out, o_out});
        cfg(5'h02, 5'h02, 16'h0004);
        slot_en = 2'b10;
        pulse(11'h020);
        chk("envelope", 2'b11, {z_out, o_out});
        pulse(11'h040);
        chk("envelope", 2'b00, {z_out, o_out});
        slot_en = 2'b11;
        pulse(11'h008);
        pulse(11'h010);
        pulse(11'h020);
        chk("envelope", 1'b1, z_out);
        pulse(11'h040);
        chk("envelope", 1'b0, z_out);
    endtask
    task t_copies;
        cfg(5'h05, 5'h07, 16'h0004);
        led = 2'b01;
        tick(2);
        chk("LED copies", 2'b11, {z_out, o_out});
        led = 2'b10;
        tick(2);
        chk("LED copies", 2'b01, {z_out, o_out});
        cfg(5'h06, 5'h13, 16'h0004);
        osc = 1'b1;
        tick(2);
        chk("LED B and oscillator", 2'b11, {z_out, o_out});
        osc = 1'b0;
        tick(2);
        chk("oscillator", 1'b0, o_out);
    endtask
    task t_irq;
        cfg(5'h01, 5'h01, 16'h0004);
        pulse(11'h080);
        tick(1);
        chk("masked", 1'b0, irq);
        wr(8'h00, 16'h0060);
        wr(8'h01, 16'h0140);
        pulse(11'h080);
        tick(1);
        chk("irq and pins", 3'b111, {irq, z_out, o_out});
        rd(8'h00, 16'h0020);
        wr(8'h00, 16'h0020);
        tick(1);
        chk("cleared", 2'b00, {irq, z_out});
        wr(8'h06, 16'h0300);
        rd(8'h06, 16'h0300);
        wr(8'h01, 16'h00E0);
        count = 8'h03;
        pulse(11'h200);
        tick(1);
        chk("at limit", 1'b0, irq);
        count = 8'h04;
        pulse(11'h200);
        tick(1);
        chk("above limit", 1'b1, irq);
        pulse(11'h400);
        tick(1);
        chk("after read", 1'b0, irq);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(4);
        rst_n = 1'b1;
        t_registers;
        t_modes;
        t_events;
        t_copies;
        t_irq;
        report_and_stop;
    end
    initial begin
        #100000;
        n_errors++;
        report_and_stop;
    end
endmodule
`default_nettype wire
